// [inc/brc_pkg.sv]
package brc_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] BRC_ADDR_RAIL_ONE_SEL = 8'h00;
  localparam logic [7:0] BRC_ADDR_RAIL_TWO_SEL = 8'h01;
  localparam logic [7:0] BRC_ADDR_RAIL_TWO_COMMAND = 8'h03;
  localparam logic [7:0] BRC_ADDR_SYSTEM_HEALTH_FLAGS = 8'h04;
  localparam logic [7:0] BRC_RAIL_TWO_COMMAND_RESET = 8'h00;
  localparam logic [7:0] BRC_SEL_RESET = 8'h00;
  localparam logic [7:0] BRC_COMMAND_WRITE_MASK = 8'h7f;
  localparam logic [6:0] BRC_DEVICE_ADDR = 7'h60;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int BRC_SLEW_LSB = 4;
  localparam int BRC_DISCHARGE_BIT = 3;
  localparam int BRC_LIGHT_LOAD_LSB = 1;
  localparam int BRC_OFF_BIT = 0;
  localparam int BRC_GO_BIT = 7;
  localparam int BRC_OVERTEMP_BIT = 2;
  localparam int BRC_RAIL_TWO_FLAG_BIT = 1;
  localparam int BRC_RAIL_ONE_FLAG_BIT = 0;
  // ------------------------------------------------------------
  // encodings and voltage map
  // ------------------------------------------------------------
  localparam logic [1:0] BRC_LL_PIN = 2'b00;
  localparam logic [1:0] BRC_LL_FORCED = 2'b01;
  localparam logic [1:0] BRC_LL_AUTO = 2'b10;
  localparam int BRC_VOLT_BASE_MV = 680;
  localparam int BRC_VOLT_STEP_MV = 10;
  typedef enum logic [1:0] {BRC_IDLE, BRC_DEV, BRC_REG, BRC_DATA} brc_state_t;
endpackage

// [verilog/brc_regs.sv]
`timescale 1ns/1ps
module brc_regs
  import brc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic switch_tick,
  input wire logic mode_pin,
  input wire logic overtemp_in,
  input wire logic rail_one_regulation_in,
  input wire logic rail_two_regulation_in,
  output logic [2:0] slew_code,
  output logic soft_discharge_en,
  output logic forced_fixed_freq,
  output logic rail_two_off,
  output logic rail_two_use_code,
  output logic [10:0] rail_two_target_mv,
  output logic [10:0] rail_two_code_mv
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic scl_prev;
  logic sda_prev;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sync_a <= 5'h1f;
      sync_b <= 5'h1f;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      sync_a <= {scl_in, sda_in, overtemp_in, rail_one_regulation_in, rail_two_regulation_in};
      sync_b <= sync_a;
      scl_prev <= sync_b[4];
      sda_prev <= sync_b[3];
    end
  end
  wire scl_s = sync_b[4];
  wire sda_s = sync_b[3];
  wire scl_rise = scl_s && !scl_prev;
  wire scl_fall = !scl_s && scl_prev;
  wire start_cond = scl_s && scl_prev && sda_prev && !sda_s;
  wire stop_cond = scl_s && scl_prev && !sda_prev && sda_s;

  // ------------------------------------------------------------
  // serial write engine
  // ------------------------------------------------------------
  brc_state_t state;
  logic [7:0] shift;
  logic [3:0] bit_cnt;
  logic [7:0] reg_addr;
  logic ack_phase;
  logic [7:0] command;
  logic [7:0] sel_one;
  logic [7:0] sel_two;
  wire byte_done = scl_rise && (bit_cnt == 4'd7) && !ack_phase;
  wire [7:0] byte_val = {shift[6:0], sda_s};
  wire dev_match = byte_val[7:1] == BRC_DEVICE_ADDR;
  wire data_write = byte_done && (state == BRC_DATA);
  wire wr_cmd = data_write && (reg_addr == BRC_ADDR_RAIL_TWO_COMMAND);
  wire wr_sel1 = data_write && (reg_addr == BRC_ADDR_RAIL_ONE_SEL);
  wire wr_sel2 = data_write && (reg_addr == BRC_ADDR_RAIL_TWO_SEL);
  // acknowledge each byte taken; a foreign address is left alone
  wire take_ack = byte_done && (state != BRC_IDLE) && ((state != BRC_DEV) || dev_match);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state <= BRC_IDLE;
      shift <= 8'h00;
      bit_cnt <= 4'h0;
      reg_addr <= 8'h00;
      ack_phase <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_cond) begin
      state <= BRC_DEV;
      bit_cnt <= 4'h0;
      ack_phase <= 1'b0;
      sda_oe <= 1'b0;
    end else if (stop_cond) begin
      state <= BRC_IDLE;
      sda_oe <= 1'b0;
    end else begin
      if (scl_rise && !ack_phase) begin
        shift <= byte_val;
        bit_cnt <= bit_cnt + 4'd1;
      end
      if (byte_done) begin
        bit_cnt <= 4'h0;
        ack_phase <= take_ack;
        unique case (state)
          BRC_DEV: state <= dev_match && !byte_val[0] ? BRC_REG : BRC_IDLE;
          BRC_REG: begin
            reg_addr <= byte_val;
            state <= BRC_DATA;
          end
          BRC_DATA: reg_addr <= reg_addr + 8'd1;
          BRC_IDLE: state <= BRC_IDLE;
        endcase
      end
      if (scl_fall && ack_phase && !sda_oe) begin
        sda_oe <= 1'b1;
      end else if (scl_fall && sda_oe) begin
        sda_oe <= 1'b0;
        ack_phase <= 1'b0;
      end
    end
  end
  assign sda_out = 1'b0;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      command <= BRC_RAIL_TWO_COMMAND_RESET;
      sel_one <= BRC_SEL_RESET;
      sel_two <= BRC_SEL_RESET;
    end else begin
      if (wr_cmd) begin
        command <= byte_val & BRC_COMMAND_WRITE_MASK;
      end
      if (wr_sel1) begin
        sel_one <= byte_val;
      end
      if (wr_sel2) begin
        sel_two <= byte_val;
      end
    end
  end

  // status is live: it mirrors the sensed conditions, reserved bits zero
  logic [7:0] health_flags;
  assign health_flags = {5'b0_0000, sync_b[2], !sync_b[0], !sync_b[1]};

  assign slew_code = command[BRC_SLEW_LSB +: 3];
  assign soft_discharge_en = command[BRC_DISCHARGE_BIT];
  assign rail_two_off = command[BRC_OFF_BIT];
  wire [1:0] ll_code = command[BRC_LIGHT_LOAD_LSB +: 2];
  // reserved code 11 falls back to the pin rather than guessing a mode
  assign forced_fixed_freq = (ll_code == BRC_LL_FORCED) ||
                             ((ll_code != BRC_LL_AUTO) && mode_pin);
  assign rail_two_use_code = sel_two[BRC_GO_BIT];

  // ------------------------------------------------------------
  // voltage map and slew stepping
  // ------------------------------------------------------------
  wire [10:0] code_mv = 11'(BRC_VOLT_BASE_MV) + 11'(sel_two[6:0]) * 11'(BRC_VOLT_STEP_MV);
  logic [7:0] tick_cnt;
  logic [10:0] target;
  wire [7:0] tick_limit = 8'(8'h01 << slew_code) - 8'h01;
  wire step_now = switch_tick && (tick_cnt >= tick_limit);
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      tick_cnt <= 8'h00;
      target <= 11'(BRC_VOLT_BASE_MV);
      rail_two_code_mv <= 11'(BRC_VOLT_BASE_MV);
    end else begin
      rail_two_code_mv <= code_mv;
      if (!rail_two_use_code || target == code_mv) begin
        tick_cnt <= 8'h00;
        target <= rail_two_use_code ? target : code_mv;
      end else if (step_now) begin
        tick_cnt <= 8'h00;
        target <= target < code_mv ? target + 11'(BRC_VOLT_STEP_MV)
                                   : target - 11'(BRC_VOLT_STEP_MV);
      end else if (switch_tick) begin
        tick_cnt <= tick_cnt + 8'h01;
      end
    end
  end
  assign rail_two_target_mv = target;
  logic unused_status;
  assign unused_status = |{health_flags, sel_one};
endmodule

// [testbench/brc_regs_props.sv]
`timescale 1ns/1ps
// ----------
// checks
// ----------
module brc_regs_props (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [2:0] slew_code,
  input wire logic soft_discharge_en,
  input wire logic rail_two_off,
  input wire logic rail_two_use_code,
  input wire logic [10:0] rail_two_target_mv,
  input wire logic [10:0] rail_two_code_mv
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  property p_code; rail_two_code_mv inside {[11'h2a8:11'h79e]}; endproperty
  a_code: assert property (p_code) else $error("code mv off map");
  property p_tgt; rail_two_target_mv inside {[11'h2a8:11'h79e]}; endproperty
  a_tgt: assert property (p_tgt) else $error("target off map");
  // without the go flag the target only shadows the code, so steps are judged while it is set
  property p_step; $changed(rail_two_target_mv) && rail_two_use_code && $past(rail_two_use_code)
    |-> rail_two_target_mv ==
    $past(rail_two_target_mv) + 11'h00a || rail_two_target_mv + 11'h00a == $past(rail_two_target_mv);
  endproperty
  a_step: assert property (p_step) else $error("target step not 10");
  property p_ack_rise; $rose(sda_oe) |-> !scl_in; endproperty
  a_ack_rise: assert property (p_ack_rise) else $error("ack rose with clock high");
  property p_ack_hold; $rose(sda_oe) |=> sda_oe [*3]; endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack too short");
  property p_ack_fall; $fell(sda_oe) |-> !scl_in; endproperty
  a_ack_fall: assert property (p_ack_fall) else $error("ack fell with clock high");
  property p_low; sda_out == 1'b0; endproperty
  a_low: assert property (p_low) else $error("data pin drives high");
  property p_upd; $changed({slew_code, soft_discharge_en, rail_two_off}) |-> !sda_oe; endproperty
  a_upd: assert property (p_upd) else $error("fields moved during ack");
endmodule
bind brc_regs brc_regs_props u_brc_regs_props (.sys_clk, .resetn, .scl_in, .sda_out, .sda_oe,
  .slew_code, .soft_discharge_en, .rail_two_off, .rail_two_use_code, .rail_two_target_mv,
  .rail_two_code_mv);

// [testbench/brc_host.sv]
`timescale 1ns/1ps
// ----------
// bus host
// ----------
module brc_host
  import brc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sda_oe,
  output logic scl_line,
  output logic sda_line
);
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  int acks = 0;
  assign scl_line = scl_q;
  // pull-up: released line reads high
  assign sda_line = sda_q & ~sda_oe;
  task automatic half(input logic s);
    repeat (8) @(negedge sys_clk);
    scl_q = s;
  endtask
  task automatic put(input logic [7:0] b);
    logic [8:0] f;
    f = {b, 1'b1};
    for (int i = 8; i >= 0; i--) begin
      sda_q = f[i];
      half(1'b1);
      if (i == 0 && sda_line === 1'b0) acks++;
      half(1'b0);
      // data moves well after the fall so no false start or stop is seen
      repeat (2) @(negedge sys_clk);
    end
  endtask
  task automatic write(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d);
    half(1'b1);
    sda_q = 1'b0;
    half(1'b0);
    put({dev, 1'b0});
    put(a);
    put(d);
    sda_q = 1'b0;
    half(1'b1);
    half(1'b1);
    sda_q = 1'b1;
  endtask
endmodule

// [testbench/buck_rail_command_status_regs_test.sv]
`timescale 1ns/1ps
// ----------
// scenarios
// ----------
module buck_rail_command_status_regs_test;
  import brc_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic switch_tick = 1'b0;
  logic mode_pin = 1'b0;
  wire logic scl, sda, sda_oe, ffreq, disc, off, use_code;
  wire logic [2:0] slew;
  wire logic [10:0] tgt, cmv;
  int fail_count = 0;
  int checks_done = 0;
  always #2 sys_clk = ~sys_clk;
  always @(negedge sys_clk) switch_tick <= ~switch_tick;
  brc_regs u_brc_regs (.sys_clk, .resetn, .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe,
    .switch_tick, .mode_pin, .overtemp_in(1'b0), .rail_one_regulation_in(1'b1),
    .rail_two_regulation_in(1'b1), .slew_code(slew), .soft_discharge_en(disc),
    .forced_fixed_freq(ffreq), .rail_two_off(off), .rail_two_use_code(use_code),
    .rail_two_target_mv(tgt), .rail_two_code_mv(cmv));
  brc_host u_brc_host (.sys_clk, .sda_oe, .scl_line(scl), .sda_line(sda));
  task automatic cmp(input string n, input logic [10:0] s, input logic [10:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic t_cmd;
    logic [1:0] ll;
    int a;
    // code 11 is reserved and never sent by a well-behaved host
    for (int m = 0; m < 3; m++) begin
      ll = m[1:0];
      mode_pin = !ll[0];
      a = u_brc_host.acks;
      u_brc_host.write(BRC_DEVICE_ADDR, 8'h03, {1'b1, ll, ll[0], !ll[0], ll, ll[1]});
      cmp("acks", 11'(u_brc_host.acks - a), 11'h003);
      cmp("slew", 11'(slew), 11'({ll, ll[0]}));
      cmp("disc", 11'(disc), 11'(!ll[0]));
      cmp("off", 11'(off), 11'(ll[1]));
      cmp("forced", 11'(ffreq), 11'(ll == 2'b01 || (ll != 2'b10 && mode_pin)));
    end
  endtask
  task automatic t_bad;
    int a;
    a = u_brc_host.acks;
    u_brc_host.write(7'h61, 8'h03, 8'h00);
    cmp("acks", 11'(u_brc_host.acks - a), 11'h000);
    cmp("off", 11'(off), 11'h001);
  endtask
  task automatic t_reset;
    @(negedge sys_clk);
    resetn = 1'b0;
    repeat (12) @(negedge sys_clk);
    cmp("slew", 11'(slew), 11'h000);
    cmp("disc", 11'(disc), 11'h000);
    cmp("off", 11'(off), 11'h000);
    cmp("go", 11'(use_code), 11'h000);
    cmp("target", tgt, 11'h2a8);
    resetn = 1'b1;
    repeat (4) @(negedge sys_clk);
    cmp("code", cmv, 11'h2a8);
  endtask
  task automatic t_slew;
    int n;
    u_brc_host.write(BRC_DEVICE_ADDR, 8'h03, 8'h00);
    cmp("off", 11'(off), 11'h000);
    u_brc_host.write(BRC_DEVICE_ADDR, 8'h01, 8'hff);
    cmp("go", 11'(use_code), 11'h001);
    cmp("code", cmv, 11'h79e);
    for (n = 0; n < 1000 && tgt !== 11'h79e; n++) @(negedge sys_clk);
    cmp("target", tgt, 11'h79e);
    if (n == 1000) final_report();
    u_brc_host.write(BRC_DEVICE_ADDR, 8'h01, 8'h00);
    cmp("code", cmv, 11'h2a8);
  endtask
  initial begin
    repeat (12) @(negedge sys_clk);
    cmp("slew", 11'(slew), 11'h000);
    cmp("disc", 11'(disc), 11'h000);
    cmp("off", 11'(off), 11'h000);
    resetn = 1'b1;
    repeat (4) @(negedge sys_clk);
    t_cmd();
    t_bad();
    t_reset();
    t_slew();
    final_report();
  end
endmodule
